// ==== verilog/omc_pkg.sv ====
`default_nettype none
package omc_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0]  WAKE_MASK_OFFSET   = 8'h00;
  localparam logic [7:0]  MODE_STATUS_OFFSET = 8'h04;
  // Wake mask field: bit 0 keypad, 1 low voltage, 2 converter, 3 serial edge,
  // 4 comparator, 5 periodic timer.
  localparam int          WAKE_MASK_WIDTH    = 6;
  localparam logic [5:0]  WAKE_MASK_RESET    = 6'h3f;
  // Mode status field positions.
  localparam int          STATUS_MODE_LSB    = 0;
  localparam int          STATUS_CAUSE_LSB   = 8;
  localparam int          STATUS_PIN_BIT     = 16;

  // Fixed program addresses, the jump opcode and the periodic-off select.
  localparam logic [13:0] RESET_FETCH_ADDR   = 14'h3ffd;
  localparam logic [13:0] VECTOR_ADDR        = 14'h3ff7;
  localparam logic [7:0]  JUMP_OPCODE        = 8'hbc;
  localparam logic [2:0]  PERIODIC_OFF       = 3'h0;

  // Depth of the pin synchroniser, and cycles waited before the mode sample.
  localparam logic [1:0]  SAMPLE_WAIT        = 2'h2;

  // Operating modes, one-hot.
  typedef enum logic [4:0] {
    MODE_SAMPLE = 5'h01,
    MODE_RUN    = 5'h02,
    MODE_DEBUG  = 5'h04,
    MODE_WAIT   = 5'h08,
    MODE_STOP   = 5'h10
  } omc_mode_type;

  // Debug commands as decoded by the serial debug front end.
  typedef enum logic [2:0] {
    CMD_MEM_ACCESS   = 3'h0,
    CMD_MEM_STATUS   = 3'h1,
    CMD_HALT         = 3'h2,
    CMD_REG_ACCESS   = 3'h3,
    CMD_TRACE        = 3'h4,
    CMD_RESUME       = 3'h5,
    CMD_FORCE_RESET  = 3'h6
  } omc_cmd_type;

  // Configuration bits held in registers outside this block.
  typedef struct packed {
    logic       stopEnableBit;
    logic       debugModeEnableBit;
    logic       lowvoltEnableBit;
    logic       lowvoltStopEnableBit;
    logic       intrefStopEnableBit;
    logic [2:0] periodicWakeSelect;
    logic       periodicWakeClockSelect;
    logic       extrefClockEnableBit;
    logic       extrefStopEnableBit;
  } omc_config_type;

  // Asynchronous wake requests (each already enabled at its source).
  typedef struct packed {
    logic periodic;
    logic comparator;
    logic serialEdge;
    logic converter;
    logic lowVolt;
    logic keypad;
  } omc_wake_type;

  // Power and clock gates driven to the rest of the chip.
  typedef struct packed {
    logic cpuClockOn;
    logic moduleClockOn;
    logic debugClockOn;
    logic regulatorFull;
    logic intClockSourceOn;
    logic lowPowerOscOn;
    logic extrefClockOn;
    logic converterStopAllowed;
  } omc_power_type;

  // Answer to one debug command.
  typedef struct packed {
    logic valid;
    logic accepted;
    logic lowPowerError;
    logic memAccessGranted;
    logic traceStep;
  } omc_resp_type;

endpackage
`default_nettype wire

// ==== verilog/omc_operating_mode_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
module omc_operating_mode_controller (
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  // AHB-Lite slave.
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  // Mode select pin, input side only.
  input  wire logic                    debugModeSelectPin,
  // Configuration bits from outside.
  input  wire omc_pkg::omc_config_type cfg,
  // CPU events, one-cycle pulses on core_clk, then the vector mask, address and interrupt levels.
  input  wire logic                    cpuWaitExec,
  input  wire logic                    cpuStopExec,
  input  wire logic                    haltToDebugInstruction,
  input  wire logic                    breakpointHit,
  input  wire logic                    vectorMaskBit,
  input  wire logic [13:0]             nextInstrAddr,
  input  wire logic                    interruptPending,
  // Asynchronous wake requests.
  input  wire omc_pkg::omc_wake_type   wakeReq,
  // Decoded debug commands.
  input  wire logic                    dbgCmdValid,
  input  wire omc_pkg::omc_cmd_type    dbgCmd,
  // CPU control.
  output logic                         pcLoad,
  output logic [13:0]                  pcLoadValue,
  output logic                         iraLoad,
  output logic [13:0]                  iraValue,
  output logic                         illegalOpcodeReset,
  output logic                         debugForceReset,
  output logic                         cpuSuspended,
  output omc_pkg::omc_mode_type        mode,
  output omc_pkg::omc_power_type       power,
  output omc_pkg::omc_resp_type        dbgResp
);

  // Synchroniser stages for the pin and the wake requests.
  logic                       pinMeta;
  logic                       pinSync;
  omc_pkg::omc_wake_type      wakeMeta;
  omc_pkg::omc_wake_type      wakeSync;
  // Mode state and its next value.
  omc_pkg::omc_mode_type      next_mode;
  logic [1:0]                 sampleCnt;
  // Software registers.
  logic [5:0]                 wakeMask;
  logic [2:0]                 wakeCause;
  logic                       pinAtSample;
  // Latched AHB address phase.
  logic                       busWrite;
  logic                       busRead;
  logic [7:0]                 busAddr;
  // Decoded events.
  logic                       lvBoth;
  logic                       stopWake;
  logic                       haltCmd;
  logic                       cmdOk;
  logic                       resetCmd;

  // Both low-voltage bits set keep the detector alive in stop.
  assign lvBoth   = cfg.lowvoltEnableBit & cfg.lowvoltStopEnableBit;
  assign haltCmd  = dbgCmdValid && (dbgCmd == omc_pkg::CMD_HALT);
  assign resetCmd = dbgCmdValid && (dbgCmd == omc_pkg::CMD_FORCE_RESET) &&
                    (mode == omc_pkg::MODE_DEBUG || mode == omc_pkg::MODE_RUN);

  // Any enabled source in the software mask ends stop; the periodic timer
  // counts only when its select is not zero.
  assign stopWake = |({wakeSync.periodic & (cfg.periodicWakeSelect != omc_pkg::PERIODIC_OFF),
                       wakeSync.comparator, wakeSync.serialEdge, wakeSync.converter,
                       wakeSync.lowVolt, wakeSync.keypad} & wakeMask);

  // The pin and the wake lines come from outside the clock domain. The pin
  // resets high because its pull-up holds it there when nothing is attached.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta  <= 1'b1;
      pinSync  <= 1'b1;
      wakeMeta <= '0;
      wakeSync <= '0;
    end else begin
      pinMeta  <= debugModeSelectPin;
      pinSync  <= pinMeta;
      wakeMeta <= wakeReq;
      wakeSync <= wakeMeta;
    end
  end

  // Command legality per mode.
  always_comb begin
    cmdOk = 1'b0;
    case (mode)
      omc_pkg::MODE_RUN: begin
        // Only memory commands, halt and forced reset while the application runs.
        cmdOk = (dbgCmd == omc_pkg::CMD_MEM_ACCESS) || (dbgCmd == omc_pkg::CMD_MEM_STATUS) ||
                (dbgCmd == omc_pkg::CMD_HALT) || (dbgCmd == omc_pkg::CMD_FORCE_RESET);
      end
      omc_pkg::MODE_DEBUG: begin
        cmdOk = 1'b1;
      end
      omc_pkg::MODE_WAIT: begin
        cmdOk = (dbgCmd == omc_pkg::CMD_HALT) || (dbgCmd == omc_pkg::CMD_MEM_STATUS);
      end
      omc_pkg::MODE_STOP: begin
        // Without debug clocks in stop nothing is heard at all.
        cmdOk = cfg.debugModeEnableBit &&
                ((dbgCmd == omc_pkg::CMD_HALT) || (dbgCmd == omc_pkg::CMD_MEM_STATUS));
      end
      default: begin
        cmdOk = 1'b0;
      end
    endcase
  end

  // Next-mode decision.
  always_comb begin
    next_mode = mode;
    case (mode)
      omc_pkg::MODE_SAMPLE: begin
        // Pin sampled once the synchroniser holds post-reset values.
        if (sampleCnt == omc_pkg::SAMPLE_WAIT) begin
          next_mode = pinSync ? omc_pkg::MODE_RUN : omc_pkg::MODE_DEBUG;
        end
      end
      omc_pkg::MODE_RUN: begin
        if (resetCmd) begin
          next_mode = omc_pkg::MODE_SAMPLE;
        end else if (haltCmd || haltToDebugInstruction || breakpointHit) begin
          next_mode = omc_pkg::MODE_DEBUG;
        end else if (cpuStopExec && cfg.stopEnableBit) begin
          next_mode = omc_pkg::MODE_STOP;
        end else if (cpuWaitExec) begin
          next_mode = omc_pkg::MODE_WAIT;
        end
      end
      omc_pkg::MODE_DEBUG: begin
        if (resetCmd) begin
          next_mode = omc_pkg::MODE_SAMPLE;
        end else if (dbgCmdValid && dbgCmd == omc_pkg::CMD_RESUME) begin
          next_mode = omc_pkg::MODE_RUN;
        end
      end
      omc_pkg::MODE_WAIT: begin
        // The halt command takes priority over an interrupt in the same cycle.
        if (haltCmd) begin
          next_mode = omc_pkg::MODE_DEBUG;
        end else if (interruptPending) begin
          next_mode = omc_pkg::MODE_RUN;
        end
      end
      omc_pkg::MODE_STOP: begin
        if (haltCmd && cfg.debugModeEnableBit) begin
          next_mode = omc_pkg::MODE_DEBUG;
        end else if (stopWake) begin
          next_mode = omc_pkg::MODE_RUN;
        end
      end
      default: begin
        next_mode = omc_pkg::MODE_SAMPLE;
      end
    endcase
  end

  // Mode register and the reset sampling counter. A forced reset from the
  // host goes back through sampling so the host may hold the pin low.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode      <= omc_pkg::MODE_SAMPLE;
      sampleCnt <= 2'h0;
    end else begin
      mode <= next_mode;
      if (next_mode == omc_pkg::MODE_SAMPLE && mode != omc_pkg::MODE_SAMPLE) begin
        sampleCnt <= 2'h0;
      end else if (mode == omc_pkg::MODE_SAMPLE && sampleCnt != omc_pkg::SAMPLE_WAIT) begin
        sampleCnt <= sampleCnt + 2'h1;
      end
    end
  end

  // Program counter steering: reset fetch, vectored wake or plain resume.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pcLoad      <= 1'b0;
      pcLoadValue <= 14'h0;
      iraLoad     <= 1'b0;
      iraValue    <= 14'h0;
    end else begin
      pcLoad  <= 1'b0;
      iraLoad <= 1'b0;
      if (mode == omc_pkg::MODE_SAMPLE && next_mode == omc_pkg::MODE_RUN) begin
        // No vector fetch: the jump placed at this address does the work.
        pcLoad      <= 1'b1;
        pcLoadValue <= omc_pkg::RESET_FETCH_ADDR;
      end else if ((mode == omc_pkg::MODE_WAIT || mode == omc_pkg::MODE_STOP) &&
                   next_mode == omc_pkg::MODE_RUN && !vectorMaskBit) begin
        pcLoad      <= 1'b1;
        pcLoadValue <= omc_pkg::VECTOR_ADDR;
        iraLoad     <= 1'b1;
        iraValue    <= nextInstrAddr;
      end
    end
  end

  // Reset and force-reset pulses for the rest of the chip.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      illegalOpcodeReset <= 1'b0;
      debugForceReset    <= 1'b0;
    end else begin
      illegalOpcodeReset <= (mode == omc_pkg::MODE_RUN) && cpuStopExec && !cfg.stopEnableBit &&
                            !haltCmd && !haltToDebugInstruction && !breakpointHit &&
                            !resetCmd;
      debugForceReset    <= resetCmd;
    end
  end

  // Clock, regulator and oscillator gates follow the mode being entered.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      power <= '{cpuClockOn: 1'b0, moduleClockOn: 1'b1, debugClockOn: 1'b1,
                 regulatorFull: 1'b1, intClockSourceOn: 1'b1, lowPowerOscOn: 1'b1,
                 extrefClockOn: 1'b0, converterStopAllowed: 1'b1};
    end else if (next_mode == omc_pkg::MODE_STOP) begin
      power.cpuClockOn           <= 1'b0;
      power.moduleClockOn        <= 1'b0;
      power.debugClockOn         <= cfg.debugModeEnableBit;
      power.regulatorFull        <= cfg.debugModeEnableBit | lvBoth;
      power.intClockSourceOn     <= cfg.debugModeEnableBit |
                                    (cfg.intrefStopEnableBit & lvBoth);
      power.lowPowerOscOn        <= !(!lvBoth && cfg.periodicWakeClockSelect);
      power.extrefClockOn        <= cfg.extrefClockEnableBit & cfg.extrefStopEnableBit &
                                    lvBoth;
      power.converterStopAllowed <= lvBoth;
    end else begin
      // CPU is clocked only in run; wait and debug keep system clocks going.
      power.cpuClockOn           <= (next_mode == omc_pkg::MODE_RUN);
      power.moduleClockOn        <= 1'b1;
      power.debugClockOn         <= 1'b1;
      power.regulatorFull        <= 1'b1;
      power.intClockSourceOn     <= 1'b1;
      power.lowPowerOscOn        <= 1'b1;
      power.extrefClockOn        <= cfg.extrefClockEnableBit;
      power.converterStopAllowed <= 1'b1;
    end
  end

  // The CPU is held while in debug, wait, stop or while the mode is sampled.
  assign cpuSuspended = (mode != omc_pkg::MODE_RUN);

  // Debug command answer, registered one cycle after the command.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dbgResp <= '0;
    end else begin
      dbgResp.valid            <= dbgCmdValid;
      dbgResp.accepted         <= dbgCmdValid && cmdOk;
      // Status commands in low power report the error and touch no memory.
      dbgResp.lowPowerError    <= dbgCmdValid && cmdOk && (dbgCmd == omc_pkg::CMD_MEM_STATUS) &&
                                  (mode == omc_pkg::MODE_WAIT ||
                                   mode == omc_pkg::MODE_STOP);
      dbgResp.memAccessGranted <= dbgCmdValid && cmdOk &&
                                  (mode == omc_pkg::MODE_RUN || mode == omc_pkg::MODE_DEBUG) &&
                                  (dbgCmd == omc_pkg::CMD_MEM_ACCESS ||
                                   dbgCmd == omc_pkg::CMD_MEM_STATUS);
      dbgResp.traceStep        <= dbgCmdValid && (mode == omc_pkg::MODE_DEBUG) &&
                                  (dbgCmd == omc_pkg::CMD_TRACE);
    end
  end

  // Wake cause and pin sample, kept for software to read.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeCause   <= 3'h0;
      pinAtSample <= 1'b1;
    end else begin
      if (mode == omc_pkg::MODE_SAMPLE && sampleCnt == omc_pkg::SAMPLE_WAIT) begin
        pinAtSample <= pinSync;
      end
      if (mode == omc_pkg::MODE_STOP && next_mode != omc_pkg::MODE_STOP) begin
        // Low bits name the source class: 1 interrupt or wake request, 2 halt command.
        wakeCause <= haltCmd ? 3'h2 : 3'h1;
      end else if (mode == omc_pkg::MODE_WAIT && next_mode != omc_pkg::MODE_WAIT) begin
        wakeCause <= haltCmd ? 3'h6 : 3'h5;
      end
    end
  end

  // AHB-Lite address phase capture. The slave never stalls, so hready is
  // simply the previous transfer ending.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busWrite <= 1'b0;
      busRead  <= 1'b0;
      busAddr  <= 8'h0;
    end else begin
      busWrite <= hsel && hready && htrans[1] && hwrite;
      busRead  <= hsel && hready && htrans[1] && !hwrite;
      busAddr  <= haddr[7:0];
    end
  end

  // Wake mask register, the one that software writes.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeMask <= omc_pkg::WAKE_MASK_RESET;
    end else if (busWrite && busAddr == omc_pkg::WAKE_MASK_OFFSET) begin
      wakeMask <= hwdata[omc_pkg::WAKE_MASK_WIDTH-1:0];
    end
  end

  // Read data is registered so it stands through the data phase.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        omc_pkg::WAKE_MASK_OFFSET: begin
          hrdata <= {26'h0, wakeMask};
        end
        omc_pkg::MODE_STATUS_OFFSET: begin
          hrdata <= {15'h0, pinAtSample, 5'h0, wakeCause, 3'h0, mode};
        end
        default: begin
          // Unmapped offsets read zero.
          hrdata <= 32'h0;
        end
      endcase
    end
  end

  // Zero wait states and always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule
`default_nettype wire

// ==== test/omc_operating_mode_controller_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the mode controller, all in the core clock domain.
module omc_operating_mode_controller_sva (
  input wire logic                    core_clk,
  input wire logic                    arst_n,
  input wire logic                    debugModeSelectPin,
  input wire omc_pkg::omc_config_type cfg,
  input wire logic                    cpuStopExec,
  input wire logic                    haltToDebugInstruction,
  input wire logic                    breakpointHit,
  input wire logic                    vectorMaskBit,
  input wire logic [13:0]             nextInstrAddr,
  input wire logic                    dbgCmdValid,
  input wire omc_pkg::omc_cmd_type    dbgCmd,
  input wire logic                    pcLoad,
  input wire logic [13:0]             pcLoadValue,
  input wire logic                    iraLoad,
  input wire logic [13:0]             iraValue,
  input wire logic                    illegalOpcodeReset,
  input wire logic                    cpuSuspended,
  input wire omc_pkg::omc_mode_type   mode,
  input wire omc_pkg::omc_power_type  power,
  input wire omc_pkg::omc_resp_type   dbgResp
);
  // One domain, so clock and reset are given once for every property.
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // The pin passes two flops, so the choice follows its value three edges back.
  property p_sample_exit;
    $past(mode) == omc_pkg::MODE_SAMPLE && mode != omc_pkg::MODE_SAMPLE |->
      mode == ($past(debugModeSelectPin, 3) ? omc_pkg::MODE_RUN : omc_pkg::MODE_DEBUG);
  endproperty
  a_sample_exit: assert property (p_sample_exit) else $error("bad mode pick");
  property p_run_fetch;
    $past(mode) == omc_pkg::MODE_SAMPLE && mode == omc_pkg::MODE_RUN |->
      pcLoad && pcLoadValue == 14'h3ffd;
  endproperty
  a_run_fetch: assert property (p_run_fetch) else $error("bad run fetch");
  property p_halt_cmd;
    mode inside {omc_pkg::MODE_RUN, omc_pkg::MODE_DEBUG} && dbgCmdValid
      && dbgCmd == omc_pkg::CMD_HALT |=> mode == omc_pkg::MODE_DEBUG && dbgResp.accepted;
  endproperty
  a_halt_cmd: assert property (p_halt_cmd) else $error("halt not taken");
  property p_suspend;
    mode == omc_pkg::MODE_DEBUG |-> cpuSuspended && !power.cpuClockOn;
  endproperty
  a_suspend: assert property (p_suspend) else $error("cpu not held");
  property p_active_only;
    dbgCmdValid && mode != omc_pkg::MODE_DEBUG && dbgCmd inside {omc_pkg::CMD_REG_ACCESS,
      omc_pkg::CMD_TRACE, omc_pkg::CMD_RESUME} |=> dbgResp.valid && !dbgResp.accepted;
  endproperty
  a_active_only: assert property (p_active_only) else $error("command leak");
  property p_wait_clocks;
    mode == omc_pkg::MODE_WAIT |-> !power.cpuClockOn && power.moduleClockOn
      && power.regulatorFull && power.intClockSourceOn;
  endproperty
  a_wait_clocks: assert property (p_wait_clocks) else $error("bad wait gates");
  // A vectored wake loads both the program counter and the return register.
  property p_vector_wake;
    $past(mode) inside {omc_pkg::MODE_WAIT, omc_pkg::MODE_STOP} && mode == omc_pkg::MODE_RUN
      && !$past(vectorMaskBit) |-> pcLoad && pcLoadValue == 14'h3ff7 && iraLoad
      && iraValue == $past(nextInstrAddr);
  endproperty
  a_vector_wake: assert property (p_vector_wake) else $error("bad vector");
  property p_low_power;
    dbgCmdValid && dbgCmd == omc_pkg::CMD_MEM_STATUS && (mode == omc_pkg::MODE_WAIT ||
      mode == omc_pkg::MODE_STOP && cfg.debugModeEnableBit) |=> dbgResp.lowPowerError
      && !dbgResp.memAccessGranted;
  endproperty
  a_low_power: assert property (p_low_power) else $error("no low power error");
  property p_illegal_stop;
    mode == omc_pkg::MODE_RUN && cpuStopExec && !cfg.stopEnableBit && !dbgCmdValid
      && !haltToDebugInstruction && !breakpointHit |=> illegalOpcodeReset
      && mode == omc_pkg::MODE_RUN;
  endproperty
  a_illegal_stop: assert property (p_illegal_stop) else $error("no illegal reset");
  property p_stop_gates;
    mode == omc_pkg::MODE_STOP && $stable(cfg) |-> !power.cpuClockOn && !power.moduleClockOn
      && power.regulatorFull == (cfg.debugModeEnableBit || cfg.lowvoltEnableBit
      && cfg.lowvoltStopEnableBit) && power.extrefClockOn == (cfg.extrefClockEnableBit
      && cfg.extrefStopEnableBit && cfg.lowvoltEnableBit && cfg.lowvoltStopEnableBit);
  endproperty
  a_stop_gates: assert property (p_stop_gates) else $error("bad stop gates");
endmodule
bind omc_operating_mode_controller omc_operating_mode_controller_sva i_sva (.*);
`default_nettype wire

// ==== test/omc_debug_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Debug host: owns the mode select pin and issues decoded commands.
module omc_debug_host_model (
  input  wire logic                 core_clk,
  output var  logic                 debugModeSelectPin,
  output var  logic                 dbgCmdValid,
  output var  omc_pkg::omc_cmd_type dbgCmd
);
  // A released pin rests high through the device pull-up.
  initial begin
    debugModeSelectPin = 1'b1;
    dbgCmdValid = 1'b0;
    dbgCmd = omc_pkg::CMD_RESUME;
  end
  // Pulls the pin low, or lets it go, from the next edge on.
  task automatic holdLow(input logic low);
    @(posedge core_clk);
    debugModeSelectPin <= ~low;
  endtask
  // One command for one cycle; afterwards the code lines carry junk.
  task automatic send(input omc_pkg::omc_cmd_type c);
    @(posedge core_clk);
    dbgCmdValid <= 1'b1;
    dbgCmd <= c;
    @(posedge core_clk);
    dbgCmdValid <= 1'b0;
    dbgCmd <= omc_pkg::omc_cmd_type'(~c);
  endtask
endmodule
`default_nettype wire

// ==== test/test_operating_mode_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_operating_mode_controller;
  logic                    core_clk, arst_n;          // Clock and reset.
  logic                    hsel, hwrite, hreadyout, hresp; // Bus control.
  logic [1:0]              htrans;                    // Transfer kind.
  logic [31:0]             haddr, hwdata, hrdata, rd; // Bus data.
  omc_pkg::omc_config_type cfg;                       // Outside config bits.
  logic                    cpuWaitExec, cpuStopExec;  // CPU event pulses.
  logic                    haltToDebugInstruction, breakpointHit;
  logic                    vectorMaskBit, interruptPending;
  logic [13:0]             nextInstrAddr, pcLoadValue, iraValue;
  omc_pkg::omc_wake_type   wakeReq;                   // Wake requests.
  logic                    debugModeSelectPin, dbgCmdValid;
  omc_pkg::omc_cmd_type    dbgCmd;                    // From the host.
  logic                    pcLoad, iraLoad, illegalOpcodeReset;
  logic                    debugForceReset, cpuSuspended;
  omc_pkg::omc_mode_type   mode;
  omc_pkg::omc_power_type  power;
  omc_pkg::omc_resp_type   dbgResp;
  int                      errCount, cmpCount;        // Tallies.

  omc_operating_mode_controller i_dut (.*, .hready(hreadyout), .hsize(3'h2));
  omc_debug_host_model i_host (.*);

  // 200 MHz clock.
  always #2.5 core_clk = ~core_clk;

  // Tallies, verdict, stop.
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single word transfer; the slave may stretch either phase.
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++n < 100);
    r = hrdata;
    if (n >= 99) begin
      errCount++;
      summarize();
    end
  endtask
  // Waits a bounded time for a mode; a miss ends the run.
  task automatic waitMode(input omc_pkg::omc_mode_type m);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
    end while (mode !== m && ++n < 40);
    if (mode !== m) begin
      chk("mode", mode, m);
      summarize();
    end
  endtask
  task automatic cmd(input omc_pkg::omc_cmd_type c, input logic acc);
    i_host.send(c);
    #1;
    chk("resp", {dbgResp.valid, dbgResp.accepted}, {1'b1, acc});
  endtask
  // Pulses one CPU event: 0 wait, 1 stop, 2 halt insn, 3 breakpoint.
  task automatic ev(input int k);
    @(posedge core_clk);
    {cpuWaitExec, cpuStopExec, haltToDebugInstruction, breakpointHit} <= 4'h8 >> k;
    @(posedge core_clk);
    {cpuWaitExec, cpuStopExec, haltToDebugInstruction, breakpointHit} <= 4'h0;
    #1;
  endtask
  // Checks the loads made by a wake back into run.
  task automatic wakeChk(input logic m);
    chk("loads", {pcLoad, iraLoad}, {~m, ~m});
    if (!m) chk("targets", {pcLoadValue, iraValue}, {14'h3ff7, nextInstrAddr});
  endtask
  // Reset long enough, then expect run with a fetch from the reset address.
  task automatic restart;
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    waitMode(omc_pkg::MODE_RUN);
    chk("fetch", {pcLoad, pcLoadValue}, {1'b1, 14'h3ffd});
  endtask

  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {cpuWaitExec, cpuStopExec, haltToDebugInstruction, breakpointHit} = '0;
    {vectorMaskBit, interruptPending, wakeReq, errCount, cmpCount} = '0;
    cfg = 11'h407;
    nextInstrAddr = 14'h0123;
    restart();
    bus(1'b0, 32'h04, 32'h0, rd);
    chk("status", rd & 32'h1001f, 32'h10002);
    bus(1'b0, 32'h00, 32'h0, rd);
    chk("wakeMask", rd, 32'h3f);
    bus(1'b1, 32'h00, 32'h2a, rd);
    bus(1'b0, 32'h00, 32'h0, rd);
    chk("wakeMask", rd, 32'h2a);
    bus(1'b1, 32'h00, 32'h3f, rd);
    bus(1'b0, 32'h08, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    // Command table in run, then in debug.
    for (int k = 0; k < 6; k++) if (k != 2) cmd(omc_pkg::omc_cmd_type'(k), k < 2);
    cmd(omc_pkg::CMD_HALT, 1'b1);
    chk("suspended", {mode, cpuSuspended}, {omc_pkg::MODE_DEBUG, 1'b1});
    for (int k = 0; k < 5; k++) begin
      cmd(omc_pkg::omc_cmd_type'(k), 1'b1);
      if (k == 4) chk("trace", dbgResp.traceStep, 1'b1);
    end
    cmd(omc_pkg::CMD_RESUME, 1'b1);
    for (int k = 2; k < 4; k++) begin
      ev(k);
      chk("mode", mode, omc_pkg::MODE_DEBUG);
      cmd(omc_pkg::CMD_RESUME, 1'b1);
    end
    // Wait and stop, first vectored, then masked.
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk);
      vectorMaskBit <= m[0];
      ev(0);
      chk("mode", mode, omc_pkg::MODE_WAIT);
      cmd(omc_pkg::CMD_MEM_ACCESS, 1'b0);
      cmd(omc_pkg::CMD_MEM_STATUS, 1'b1);
      @(posedge core_clk);
      interruptPending <= 1'b1;
      waitMode(omc_pkg::MODE_RUN);
      wakeChk(m[0]);
      @(posedge core_clk);
      interruptPending <= 1'b0;
      cfg <= m[0] ? 11'h7c7 : 11'h407;
      ev(1);
      chk("power", power, m[0] ? 8'h3f : 8'h00);
      if (m == 0) cmd(omc_pkg::CMD_HALT, 1'b0);
      @(posedge core_clk);
      wakeReq <= 6'h20;
      repeat (6) @(posedge core_clk);
      #1;
      chk("mode", mode, omc_pkg::MODE_STOP);
      @(posedge core_clk);
      wakeReq <= 6'h21;
      waitMode(omc_pkg::MODE_RUN);
      wakeChk(m[0]);
      @(posedge core_clk);
      wakeReq <= 6'h00;
    end
    ev(0);
    cmd(omc_pkg::CMD_HALT, 1'b1);
    chk("mode", mode, omc_pkg::MODE_DEBUG);
    cmd(omc_pkg::CMD_RESUME, 1'b1);
    @(posedge core_clk);
    cfg <= 11'h007;
    ev(1);
    chk("illegal", {illegalOpcodeReset, mode}, {1'b1, omc_pkg::MODE_RUN});
    @(posedge core_clk);
    cfg <= 11'h7c7;
    ev(1);
    cmd(omc_pkg::CMD_HALT, 1'b1);
    cmd(omc_pkg::CMD_REG_ACCESS, 1'b1);
    cmd(omc_pkg::CMD_RESUME, 1'b1);
    // Host keeps the pin low across a forced reset.
    i_host.holdLow(1'b1);
    cmd(omc_pkg::CMD_FORCE_RESET, 1'b1);
    chk("forceReset", debugForceReset, 1'b1);
    waitMode(omc_pkg::MODE_DEBUG);
    i_host.holdLow(1'b0);
    cmd(omc_pkg::CMD_RESUME, 1'b1);
    ev(1);
    restart();
    summarize();
  end
endmodule
`default_nettype wire
